/* File: logic/rgarb_pkg.sv */
// Shared constants and types for the request/grant to hold/acknowledge bus arbiter.
//
// Notes on behaviour
// - A coprocessor request on the first line makes the bridge raise its hold request to the host.
// - Once the host acknowledges the hold, the bridge sends a grant pulse back on the first line.
// - A third-master request is passed to whichever party owns the bus, translated to that party's handshake.
// - While the coprocessor owns the bus, a third-master request becomes a request pulse on the second line.
// - A grant pulse from the coprocessor on the second line makes the bridge raise the third-master acknowledge.
// - When the third-master request falls, the bridge sends a release pulse to the coprocessor on the second line.
// - Request to acknowledge latency is at most the host, coprocessor and bridge latencies added together.

`default_nettype none

package rgarb_pkg;

    // ----------------------------------------------------------------
    // Timing and idle levels
    // ----------------------------------------------------------------
    // Cycles after a driven pulse during which its own echo is ignored.
    localparam logic [1:0] RGARB_ECHO_CYC   = 2'h3;
    localparam logic [1:0] RGARB_ECHO_NONE  = 2'h0;
    localparam logic       RGARB_LINE_IDLE  = 1'h1;
    localparam logic       RGARB_LINE_PULSE = 1'h0;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    // Drive side of an open-drain request/grant line.
    typedef struct packed {
        logic level;
        logic oe;
    } rgarb_pin_t;

    typedef enum logic [3:0] {
        RGARB_ST_HOST,
        RGARB_ST_CP_HOLD,
        RGARB_ST_CP_OWN,
        RGARB_ST_CP_REQ3,
        RGARB_ST_TM_CP,
        RGARB_ST_TM_HOLD,
        RGARB_ST_TM_HOST,
        RGARB_ST_DROP
    } rgarb_state_t;

endpackage : rgarb_pkg

`default_nettype wire

/* File: logic/rgarb_rqgt_line.sv */
// One open-drain request/grant line: pulse detection and pulse driving.

`timescale 1ns/1ps
`default_nettype none

module rgarb_rqgt_line
(
    // Clock and reset
    input  wire logic              ref_clk,
    input  wire logic              rst,
    // Pin
    input  wire logic              pin_level,
    output rgarb_pkg::rgarb_pin_t  pin_drv,
    // Arbiter side
    input  wire logic              send_pulse,
    output logic                   pulse_seen
);
    import rgarb_pkg::*;

    logic        sync1_r;
    logic        sync2_r;
    logic        prev_r;
    logic [1:0]  mask_r;
    rgarb_pin_t  drv_r;
    logic        seen_r;
    logic        sync1_nxt;
    logic        sync2_nxt;
    logic        prev_nxt;
    logic [1:0]  mask_nxt;
    rgarb_pin_t  drv_nxt;
    logic        seen_nxt;

    // ----------------------------------------------------------------
    // Next values
    // ----------------------------------------------------------------
    // Our own pulse comes back through the synchroniser, so detection is
    // masked for a few cycles after driving. A far-end pulse landing in that
    // window is missed; the protocol never sends one there.
    always_comb
    begin
        sync1_nxt     = pin_level;
        sync2_nxt     = sync1_r;
        prev_nxt      = sync2_r;
        drv_nxt.oe    = send_pulse;
        drv_nxt.level = send_pulse ? RGARB_LINE_PULSE : RGARB_LINE_IDLE;
        if (send_pulse)
            mask_nxt = RGARB_ECHO_CYC;
        else if (mask_r != RGARB_ECHO_NONE)
            mask_nxt = mask_r - 2'h1;
        else
            mask_nxt = RGARB_ECHO_NONE;
        seen_nxt = prev_r && !sync2_r && (mask_r == RGARB_ECHO_NONE) && !drv_r.oe;
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            sync1_r       <= RGARB_LINE_IDLE;
            sync2_r       <= RGARB_LINE_IDLE;
            prev_r        <= RGARB_LINE_IDLE;
            mask_r        <= RGARB_ECHO_NONE;
            drv_r.oe      <= 1'h0;
            drv_r.level   <= RGARB_LINE_IDLE;
            seen_r        <= 1'h0;
        end
        else
        begin
            sync1_r       <= sync1_nxt;
            sync2_r       <= sync2_nxt;
            prev_r        <= prev_nxt;
            mask_r        <= mask_nxt;
            drv_r         <= drv_nxt;
            seen_r        <= seen_nxt;
        end
    end

    assign pin_drv    = drv_r;
    assign pulse_seen = seen_r;

endmodule : rgarb_rqgt_line

`default_nettype wire

/* File: logic/rgarb_top.sv */
// Bus arbiter bridging a pulsed request/grant coprocessor and two hold/acknowledge masters.

`timescale 1ns/1ps
`default_nettype none

module rgarb_top
(
    // Clock and reset
    input  wire logic              ref_clk,
    input  wire logic              rst,
    // Host processor hold handshake
    output logic                   hold_req,
    input  wire logic              hold_ack,
    // Coprocessor first request/grant line
    input  wire logic              coproc_req_grant_a_level,
    output rgarb_pkg::rgarb_pin_t  coproc_req_grant_a_drv,
    // Coprocessor second request/grant line
    input  wire logic              coproc_req_grant_b_level,
    output rgarb_pkg::rgarb_pin_t  coproc_req_grant_b_drv,
    // Third bus master hold handshake
    input  wire logic              third_master_bus_req,
    output logic                   third_master_bus_ack
);
    import rgarb_pkg::*;

    rgarb_state_t  state_r;
    rgarb_state_t  state_nxt;
    logic          hold_r;
    logic          hold_nxt;
    logic          ack_r;
    logic          ack_nxt;
    logic          cp_pend_r;
    logic          cp_pend_nxt;
    logic          hlda_s1_r;
    logic          hlda_s2_r;
    logic          treq_s1_r;
    logic          treq_s2_r;
    logic          send_a;
    logic          send_b;
    logic          seen_a;
    logic          seen_b;
    logic          cp_req_evt;

    // ----------------------------------------------------------------
    // Request/grant lines
    // ----------------------------------------------------------------
    rgarb_rqgt_line u_line_a
    (
        .ref_clk    (ref_clk),
        .rst        (rst),
        .pin_level  (coproc_req_grant_a_level),
        .pin_drv    (coproc_req_grant_a_drv),
        .send_pulse (send_a),
        .pulse_seen (seen_a)
    );

    rgarb_rqgt_line u_line_b
    (
        .ref_clk    (ref_clk),
        .rst        (rst),
        .pin_level  (coproc_req_grant_b_level),
        .pin_drv    (coproc_req_grant_b_drv),
        .send_pulse (send_b),
        .pulse_seen (seen_b)
    );

    // ----------------------------------------------------------------
    // Arbitration next state
    // ----------------------------------------------------------------
    // A coprocessor request pulse arriving while the bus is elsewhere is
    // latched so it is served once the host has the bus back.
    always_comb
    begin
        cp_req_evt = seen_a && (state_r == RGARB_ST_HOST || state_r == RGARB_ST_TM_HOLD ||
                                state_r == RGARB_ST_TM_HOST || state_r == RGARB_ST_DROP);
        state_nxt   = state_r;
        hold_nxt    = hold_r;
        ack_nxt     = ack_r;
        cp_pend_nxt = cp_pend_r || cp_req_evt;
        send_a      = 1'h0;
        send_b      = 1'h0;
        unique case (state_r)
            RGARB_ST_HOST:
            begin
                if (cp_pend_r || cp_req_evt)
                begin
                    hold_nxt    = 1'h1;
                    cp_pend_nxt = 1'h0;
                    state_nxt   = RGARB_ST_CP_HOLD;
                end
                else if (treq_s2_r)
                begin
                    hold_nxt  = 1'h1;
                    state_nxt = RGARB_ST_TM_HOLD;
                end
            end
            RGARB_ST_CP_HOLD:
            begin
                if (hlda_s2_r)
                begin
                    send_a    = 1'h1;
                    state_nxt = RGARB_ST_CP_OWN;
                end
            end
            RGARB_ST_CP_OWN:
            begin
                if (seen_a)
                begin
                    hold_nxt  = 1'h0;
                    state_nxt = RGARB_ST_DROP;
                end
                else if (treq_s2_r)
                begin
                    send_b    = 1'h1;
                    state_nxt = RGARB_ST_CP_REQ3;
                end
            end
            RGARB_ST_CP_REQ3:
            begin
                // The coprocessor floats its outputs before this pulse.
                if (seen_b)
                begin
                    ack_nxt   = 1'h1;
                    state_nxt = RGARB_ST_TM_CP;
                end
            end
            RGARB_ST_TM_CP:
            begin
                if (!treq_s2_r)
                begin
                    ack_nxt   = 1'h0;
                    send_b    = 1'h1;
                    state_nxt = RGARB_ST_CP_OWN;
                end
            end
            RGARB_ST_TM_HOLD:
            begin
                if (hlda_s2_r)
                begin
                    ack_nxt   = 1'h1;
                    state_nxt = RGARB_ST_TM_HOST;
                end
            end
            RGARB_ST_TM_HOST:
            begin
                if (!treq_s2_r)
                begin
                    ack_nxt   = 1'h0;
                    hold_nxt  = 1'h0;
                    state_nxt = RGARB_ST_DROP;
                end
            end
            RGARB_ST_DROP:
            begin
                // Waiting for the host to take back the bus avoids a new
                // hold being read as the old acknowledge.
                if (!hlda_s2_r)
                    state_nxt = RGARB_ST_HOST;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            state_r   <= RGARB_ST_HOST;
            hold_r    <= 1'h0;
            ack_r     <= 1'h0;
            cp_pend_r <= 1'h0;
            hlda_s1_r <= 1'h0;
            hlda_s2_r <= 1'h0;
            treq_s1_r <= 1'h0;
            treq_s2_r <= 1'h0;
        end
        else
        begin
            state_r   <= state_nxt;
            hold_r    <= hold_nxt;
            ack_r     <= ack_nxt;
            cp_pend_r <= cp_pend_nxt;
            hlda_s1_r <= hold_ack;
            hlda_s2_r <= hlda_s1_r;
            treq_s1_r <= third_master_bus_req;
            treq_s2_r <= treq_s1_r;
        end
    end

    assign hold_req             = hold_r;
    assign third_master_bus_ack = ack_r;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    a_cp_hold_req: assert property (state_r == RGARB_ST_HOST && seen_a |=> hold_req ##1 hold_req)
        else $error("Coprocessor request did not raise hold.");
    a_cp_grant_pulse: assert property (state_r == RGARB_ST_CP_HOLD && hlda_s2_r |=>
        (coproc_req_grant_a_drv.oe && !coproc_req_grant_a_drv.level) ##1 !coproc_req_grant_a_drv.oe)
        else $error("Grant pulse on first line missing or too long.");
    a_tm_route_host: assert property (state_r == RGARB_ST_HOST && treq_s2_r && !cp_pend_r && !seen_a
        |=> hold_r && !ack_r && state_r == RGARB_ST_TM_HOLD)
        else $error("Third master request not routed to host.");
    a_tm_route_cp: assert property (state_r == RGARB_ST_CP_OWN && treq_s2_r && !seen_a
        |=> coproc_req_grant_b_drv.oe && !ack_r)
        else $error("Third master request not routed to coprocessor.");
    a_cp_yield_ack: assert property (state_r == RGARB_ST_CP_REQ3 && seen_b |=> third_master_bus_ack)
        else $error("Acknowledge missing after coprocessor grant.");
    a_release_pulse: assert property (state_r == RGARB_ST_TM_CP && !treq_s2_r
        |=> !third_master_bus_ack && coproc_req_grant_b_drv.oe && !coproc_req_grant_b_drv.level)
        else $error("Release pulse missing on second line.");
    a_ack_latency: assert property (state_r == RGARB_ST_TM_HOLD && hlda_s2_r |=> third_master_bus_ack)
        else $error("Bridge added latency to acknowledge.");
    a_ack_after_hlda: assert property ($rose(ack_r) |-> hold_r &&
        ($past(hlda_s2_r) || $past(seen_b)))
        else $error("Acknowledge raised without host or coprocessor grant.");
    a_hold_drop: assert property (state_r == RGARB_ST_CP_OWN && seen_a |=> !hold_req)
        else $error("Hold not dropped after coprocessor release.");

    c_cp_cycle: cover property (state_r == RGARB_ST_CP_OWN && seen_a);
    c_tm_via_cp: cover property (state_r == RGARB_ST_TM_CP && !treq_s2_r);
    c_tm_via_host: cover property (state_r == RGARB_ST_TM_HOST && !treq_s2_r);
    c_cp_pending: cover property (cp_req_evt && state_r != RGARB_ST_HOST);

endmodule : rgarb_top

`default_nettype wire

/* File: bench/rgarb_partner.sv */
// Behavioural host processor and coprocessor facing the bus arbiter.
`timescale 1ns/1ps
`default_nettype none

module rgarb_partner
(
    // Clock and reset
    input  wire logic                  ref_clk,
    input  wire logic                  rst,
    // Host hold handshake
    input  wire logic                  hold_req,
    output logic                       hold_ack,
    input  wire logic                  host_slow,
    // Coprocessor request/grant lines
    input  wire rgarb_pkg::rgarb_pin_t a_drv,
    input  wire rgarb_pkg::rgarb_pin_t b_drv,
    input  wire logic                  cp_pulse_a,
    output logic                       a_level,
    output logic                       b_level
);
    import rgarb_pkg::*;

    logic [3:0] host_cnt_r;
    logic [3:0] cp_cnt_r;
    logic       cp_a_low_r;
    logic       cp_b_low_r;
    logic       yielded_r;
    logic       b_seen;

    assign b_seen  = b_drv.oe && (b_drv.level == RGARB_LINE_PULSE);
    // Both lines are pulled up, so a line nobody pulls low reads high.
    assign a_level = !(cp_a_low_r || (a_drv.oe && (a_drv.level == RGARB_LINE_PULSE)));
    assign b_level = !(cp_b_low_r || b_seen);

    always @(posedge ref_clk)
    begin
        if (rst)
        begin
            hold_ack   <= 1'h0;
            host_cnt_r <= 4'h0;
            cp_cnt_r   <= 4'h0;
            cp_a_low_r <= 1'h0;
            cp_b_low_r <= 1'h0;
            yielded_r  <= 1'h0;
        end
        else
        begin
            host_cnt_r <= 4'h0;
            if (hold_req != hold_ack)
            begin
                host_cnt_r <= host_cnt_r + 4'h1;
                if (host_cnt_r == (host_slow ? 4'h6 : 4'h0))
                begin
                    hold_ack   <= hold_req;
                    host_cnt_r <= 4'h0;
                end
            end
            cp_a_low_r <= cp_pulse_a;
            cp_b_low_r <= 1'h0;
            if (cp_cnt_r != 4'h0)
            begin
                cp_cnt_r <= cp_cnt_r - 4'h1;
                // The outputs are floated during the countdown, before the grant goes out.
                if (cp_cnt_r == 4'h1)
                begin
                    cp_b_low_r <= 1'h1;
                end
            end
            else if (b_seen && !yielded_r)
            begin
                cp_cnt_r  <= 4'h4;
                yielded_r <= 1'h1;
            end
            else if (b_seen)
            begin
                yielded_r <= 1'h0;
            end
        end
    end
endmodule : rgarb_partner

`default_nettype wire

/* File: bench/reqgrant_hold_bus_arbiter_tb.sv */
// Self-checking testbench for the request/grant to hold/acknowledge bus arbiter.
`timescale 1ns/1ps
`default_nettype none

module reqgrant_hold_bus_arbiter_tb;
    import rgarb_pkg::*;

    logic       ref_clk = 1'h0;
    logic       rst = 1'h1;
    logic       hold_req;
    logic       hold_ack;
    logic       a_level;
    logic       b_level;
    logic       req = 1'h0;
    logic       ack;
    logic       host_slow = 1'h0;
    logic       cp_pulse_a = 1'h0;
    rgarb_pin_t a_drv;
    rgarb_pin_t b_drv;
    int         fails = 0;
    int         checks_done = 0;
    string      out_name [4] = '{"hold_req", "bus_ack", "a_pulse", "b_pulse"};

    always #50 ref_clk = ~ref_clk;

    rgarb_top i_rgarb_top
    (
        .ref_clk(ref_clk), .rst(rst), .hold_req(hold_req), .hold_ack(hold_ack),
        .coproc_req_grant_a_level(a_level), .coproc_req_grant_a_drv(a_drv),
        .coproc_req_grant_b_level(b_level), .coproc_req_grant_b_drv(b_drv),
        .third_master_bus_req(req), .third_master_bus_ack(ack)
    );

    rgarb_partner i_rgarb_partner
    (
        .ref_clk(ref_clk), .rst(rst), .hold_req(hold_req), .hold_ack(hold_ack),
        .host_slow(host_slow), .a_drv(a_drv), .b_drv(b_drv),
        .cp_pulse_a(cp_pulse_a), .a_level(a_level), .b_level(b_level)
    );

    task automatic print_verdict();
        if (fails == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : print_verdict

    task automatic chk(input string what, input logic exp, input logic got);
        checks_done++;
        if (got !== exp)
        begin
            fails++;
            $display("[FAIL] %s expected %b seen %b", what, exp, got);
        end
    endtask : chk

    function automatic logic sig(input int sel);
        case (sel)
            0: return hold_req;
            1: return ack;
            2: return a_drv.oe && (a_drv.level == RGARB_LINE_PULSE);
            default: return b_drv.oe && (b_drv.level == RGARB_LINE_PULSE);
        endcase
    endfunction : sig

    task automatic step(input int k);
        repeat (k) @(posedge ref_clk);
        #1;
    endtask : step

    // Bounded wait for a design output; n returns the cycles spent.
    task automatic wait_sig(input int sel, input logic val, input int lim, output int n);
        n = 0;
        while (sig(sel) !== val)
        begin
            step(1);
            n++;
            if (n > lim)
            begin
                fails++;
                $display("[FAIL] %s expected %b seen %b", out_name[sel], val, sig(sel));
                print_verdict();
            end
        end
    endtask : wait_sig

    task automatic cp_pulse();
        @(posedge ref_clk);
        cp_pulse_a <= 1'h1;
        @(posedge ref_clk);
        cp_pulse_a <= 1'h0;
        #1;
    endtask : cp_pulse

    task automatic set_req(input logic v);
        @(posedge ref_clk);
        req <= v;
        #1;
    endtask : set_req

    task automatic t_reset();
        chk("hold_req", 1'h0, hold_req);
        chk("bus_ack", 1'h0, ack);
        chk("a_oe", 1'h0, a_drv.oe);
        chk("b_oe", 1'h0, b_drv.oe);
    endtask : t_reset

    task automatic t_cp_take(input logic slow);
        int n;
        @(posedge ref_clk);
        host_slow <= slow;
        cp_pulse();
        wait_sig(0, 1'h1, 8, n);
        chk("a_grant_early", 1'h0, sig(2));
        wait_sig(2, 1'h1, 20, n);
        chk("hold_ack_at_grant", 1'h1, hold_ack);
        step(1);
        chk("a_grant_width", 1'h0, a_drv.oe);
    endtask : t_cp_take

    task automatic t_cp_release();
        int n;
        step(5);
        cp_pulse();
        wait_sig(0, 1'h0, 8, n);
        chk("bus_ack_idle", 1'h0, ack);
        wait_sig(0, 1'h0, 1, n);
        step(14);
    endtask : t_cp_release

    task automatic t_host_third(input logic slow);
        int n;
        int m;
        @(posedge ref_clk);
        host_slow <= slow;
        set_req(1'h1);
        wait_sig(0, 1'h1, 6, n);
        chk("bus_ack_before_hlda", 1'h0, ack);
        wait_sig(1, 1'h1, 16, m);
        chk("hold_ack_at_bus_ack", 1'h1, hold_ack);
        chk("latency_host", 1'h1, (n + m) <= (slow ? 15 : 9));
        step(4);
        set_req(1'h0);
        wait_sig(1, 1'h0, 6, n);
        wait_sig(0, 1'h0, 6, n);
        step(14);
    endtask : t_host_third

    task automatic t_cp_third(input logic slow);
        int n;
        int m;
        t_cp_take(slow);
        step(5);
        set_req(1'h1);
        wait_sig(3, 1'h1, 8, n);
        chk("bus_ack_before_grant", 1'h0, ack);
        wait_sig(1, 1'h1, 14, m);
        chk("latency_coproc", 1'h1, (n + m) <= 16);
        chk("hold_kept", 1'h1, hold_req);
        step(4);
        set_req(1'h0);
        wait_sig(1, 1'h0, 6, n);
        wait_sig(3, 1'h1, 6, n);
        step(1);
        chk("b_release_width", 1'h0, b_drv.oe);
        chk("hold_after_release", 1'h1, hold_req);
        t_cp_release();
    endtask : t_cp_third

    initial
    begin
        repeat (5) @(posedge ref_clk);
        rst <= 1'h0;
        step(2);
        t_reset();
        t_cp_take(1'h0);
        t_cp_release();
        t_cp_take(1'h1);
        t_cp_release();
        t_host_third(1'h0);
        t_host_third(1'h1);
        t_cp_third(1'h0);
        t_cp_third(1'h1);
        print_verdict();
    end
endmodule : reqgrant_hold_bus_arbiter_tb

`default_nettype wire
